// *** shared/tpa_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the transmit phase-align stage
`ifndef TPA_REGS_SVH
`define TPA_REGS_SVH
// ==========================================================
// Register map (byte addresses)
`define TPA_CTRL_OFS        8'h00
`define TPA_STAT_OFS        8'h04
// ==========================================================
// Control fields
`define TPA_CTRL_CKSEL      0
`define TPA_CTRL_RECENTER   1
`define TPA_CTRL_BIST_N     2
`define TPA_CTRL_OE1        3
`define TPA_CTRL_OE2        4
`define TPA_CTRL_RATE       5
`define TPA_CTRL_HALF       6
`define TPA_CTRL_W          7
`define TPA_CTRL_RST        7'h1e
// ==========================================================
// Status fields
`define TPA_STAT_ERR        0
`define TPA_STAT_BUF_ERR    1
`define TPA_STAT_REF_LOST   2
`define TPA_STAT_PLL_DOWN   3
`define TPA_STAT_RC_BUSY    4
`define TPA_STAT_LVL_LSB    8
// ==========================================================
// Timing
`define TPA_CLK_NS          10
`define TPA_REF_LOSS_NS     200
`define TPA_REF_LOSS_CYC    (`TPA_REF_LOSS_NS / `TPA_CLK_NS)
`define TPA_REF_QTR_NS      31
`define TPA_REF_QTR_CYC     (`TPA_REF_QTR_NS / `TPA_CLK_NS)
`define TPA_BIST_LEN        511
`endif

// *** shared/tpa_pkg.sv ***
// Types shared by the transmit phase-align stage
package tpa_pkg;
    // Recenter sequence, one bit changes per step except CLEAR back to IDLE
    typedef enum logic [1:0]
    {
        TPA_RC_IDLE  = 2'b00,
        TPA_RC_ARM   = 2'b01,
        TPA_RC_CLEAR = 2'b11
    } tpa_rc_state_t;
endpackage

// *** shared/tpa_fifo_if.sv ***
// Carrier between the stage and its phase-align buffer
`timescale 1ns/1ps
interface tpa_fifo_if #(parameter int W = 10, parameter int LW = 4);
    logic          wr_valid;
    logic [W-1:0]  wr_data;
    logic          wr_ready;
    logic          rd_ready;
    logic          rd_valid;
    logic [W-1:0]  rd_data;
    logic          recenter;
    logic          overflow;
    logic          underflow;
    logic [LW-1:0] level;
    modport ctrl (output wr_valid, wr_data, rd_ready, recenter,
                  input  wr_ready, rd_valid, rd_data, overflow, underflow, level);
    modport buf_side (input  wr_valid, wr_data, rd_ready, recenter,
                      output wr_ready, rd_valid, rd_data, overflow, underflow, level);
endinterface

// *** verilog/tpa_fifo.sv ***
// Phase-align buffer: small character FIFO with a recentre control
`timescale 1ns/1ps
module tpa_fifo
    import tpa_pkg::*;
#(
    parameter int W     = 10,
    parameter int DEPTH = 8,
    parameter int LW    = 4
)
(
    input wire logic hclk,
    input wire logic hresetn,
    tpa_fifo_if.buf_side f
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [LW-1:0] HALF = LW'(DEPTH / 2);

    logic [W-1:0]  mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [LW-1:0] cnt_ff;
    logic          ovf_ff;
    logic          unf_ff;
    logic          do_wr;
    logic          do_rd;

    // Full refuses, empty cannot supply
    assign f.wr_ready  = (cnt_ff != LW'(DEPTH));
    assign f.rd_valid  = (cnt_ff != '0);
    assign f.rd_data   = mem_ff[rd_ptr_ff];
    assign f.level     = cnt_ff;
    assign f.overflow  = ovf_ff;
    assign f.underflow = unf_ff;
    assign do_wr       = f.wr_valid && f.wr_ready && !f.recenter;
    assign do_rd       = f.rd_ready && f.rd_valid && !f.recenter;

    // ==========================================================
    // Storage
    always_ff @(posedge hclk)
    begin
        if (do_wr)
            mem_ff[wr_ptr_ff] <= f.wr_data;
    end

    // Pointers; recentre leaves half a buffer of slack either way
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_ptr_ff <= AW'(DEPTH / 2);
            rd_ptr_ff <= '0;
            cnt_ff    <= HALF;
        end
        else if (f.recenter)
        begin
            wr_ptr_ff <= AW'(DEPTH / 2); // RULE14
            rd_ptr_ff <= '0;
            cnt_ff    <= HALF;
        end
        else
        begin
            if (do_wr)
                wr_ptr_ff <= AW'(wr_ptr_ff + 1'b1);
            if (do_rd)
                rd_ptr_ff <= AW'(rd_ptr_ff + 1'b1);
            cnt_ff <= LW'(cnt_ff + LW'(do_wr) - LW'(do_rd));
        end
    end

    // One-cycle flags for a refused write or a starved read
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ovf_ff <= 1'b0;
            unf_ff <= 1'b0;
        end
        else
        begin
            ovf_ff <= f.wr_valid && !f.wr_ready && !f.recenter;
            unf_ff <= f.rd_ready && !f.rd_valid && !f.recenter;
        end
    end
endmodule

// *** verilog/tpa_top.sv ***
// Transmit parallel input stage: capture, phase-align buffer and path error reporting
`timescale 1ns/1ps
`include "tpa_regs.svh"

// Behaviour
// RULE1 - Characters are registered on the rising edge of the chosen capture clock.
// RULE2 - Select 0 captures on the host input clock, otherwise on the reference clock.
// RULE3 - Buffer underflow or overflow raises the path error until the buffer is recentred.
// RULE4 - Writing 0 to the recenter latch initialises the phase relation of the two clocks.
// RULE5 - With self-test enabled (0) the error pulses for one character clock per 511 characters.
// RULE6 - Both serial output enables at 0 power the PLL down and hold the error high.
// RULE7 - The error is high whenever the reference clock is absent.
// RULE8 - The error is timed by the reference clock, with enable and loss events asynchronous.
// RULE9 - The host keeps its input clock frequency-coherent with the transmit clock output.
// RULE10 - Phase drift beyond the buffer capacity raises the error to signal lost data.
// RULE11 - A low error means the buffer is initialised and characters are captured correctly.
// RULE12 - The clock output runs at the reference rate for rate select 0 and twice it for 1.
// RULE13 - With half-rate reference capture, characters are sampled on both reference edges.
// RULE14 - The buffer is a small FIFO recentred so that permitted drift causes no false error.
// RULE15 - A recenter request is aligned to both capture and character timing before it acts. The code acts after the first capture or character edge.
module tpa_top
    import tpa_pkg::*;
#(
    parameter int W     = 10,
    parameter int DEPTH = 8
)
(
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout,
    output logic [31:0]       hrdata,
    output logic              hresp,
    input  wire logic [W-1:0] tx_char_in,
    input  wire logic         tx_host_input_clock,
    input  wire logic         tx_reference_clock,
    output logic [W-1:0]      tx_char_out,
    output logic              tx_char_valid,
    output logic              tx_clock_out,
    output logic              tx_path_error,
    output logic              tx_synth_pll_powerdown
);
    localparam int LW = $clog2(DEPTH) + 1;

    // ==========================================================
    // Pin synchronisers
    logic [W-1:0]  chr_s1_ff, chr_s2_ff;
    logic          hck_s1_ff, hck_s2_ff, hck_d_ff;
    logic          ref_s1_ff, ref_s2_ff, ref_d_ff;
    logic          hck_rise, ref_rise, ref_fall;

    // Two stages before anything looks at a pin
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            chr_s1_ff <= '0;
            chr_s2_ff <= '0;
            hck_s1_ff <= 1'b0;
            hck_s2_ff <= 1'b0;
            hck_d_ff  <= 1'b0;
            ref_s1_ff <= 1'b0;
            ref_s2_ff <= 1'b0;
            ref_d_ff  <= 1'b0;
        end
        else
        begin
            chr_s1_ff <= tx_char_in;
            chr_s2_ff <= chr_s1_ff;
            hck_s1_ff <= tx_host_input_clock;
            hck_s2_ff <= hck_s1_ff;
            hck_d_ff  <= hck_s2_ff;
            ref_s1_ff <= tx_reference_clock;
            ref_s2_ff <= ref_s1_ff;
            ref_d_ff  <= ref_s2_ff;
        end
    end

    assign hck_rise = hck_s2_ff && !hck_d_ff;
    assign ref_rise = ref_s2_ff && !ref_d_ff;
    assign ref_fall = !ref_s2_ff && ref_d_ff;

    // ==========================================================
    // Register bus slave (zero wait state)
    logic [`TPA_CTRL_W-1:0] ctrl_ff;
    logic                   wr_pend_ff;
    logic [7:0]             wr_addr_ff;
    logic                   acc;
    logic [31:0]            stat_word;
    logic                   rc_write;

    assign acc = hsel && hready && htrans[1];

    // Address phase: latch write target, prepare read data
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            hrdata     <= 32'h0000_0000;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
        end
        else
        begin
            wr_pend_ff <= acc && hwrite;
            wr_addr_ff <= haddr[7:0];
            hreadyout  <= 1'b1;
            hresp      <= 1'b0; // Always OKAY; unmapped reads give zero
            if (acc && !hwrite)
            begin
                case (haddr[7:0])
                    `TPA_CTRL_OFS: hrdata <= {25'h0, ctrl_ff};
                    `TPA_STAT_OFS: hrdata <= stat_word;
                    default:       hrdata <= 32'h0000_0000;
                endcase
            end
            else
                hrdata <= 32'h0000_0000;
        end
    end

    // Data phase: control word update
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl_ff <= `TPA_CTRL_RST;
        else if (wr_pend_ff && wr_addr_ff == `TPA_CTRL_OFS)
            ctrl_ff <= hwdata[`TPA_CTRL_W-1:0];
    end

    // Only a written 0 starts a recentre
    assign rc_write = wr_pend_ff && (wr_addr_ff == `TPA_CTRL_OFS) && !hwdata[`TPA_CTRL_RECENTER]; // RULE4

    // ==========================================================
    // Capture and character strobes
    logic sel_ref, cap_stb, chr_stb, pll_down;

    assign sel_ref  = ctrl_ff[`TPA_CTRL_CKSEL];
    assign pll_down = !ctrl_ff[`TPA_CTRL_OE1] && !ctrl_ff[`TPA_CTRL_OE2];
    // Host clock for select 0, else reference, both edges at half rate
    assign cap_stb  = sel_ref ? (ref_rise || (ctrl_ff[`TPA_CTRL_HALF] && ref_fall)) // RULE13
                              : hck_rise; // RULE1 RULE2
    // Character clock doubles with rate select or half-rate reference
    assign chr_stb  = !pll_down && (ref_rise ||
                      ((ctrl_ff[`TPA_CTRL_RATE] || ctrl_ff[`TPA_CTRL_HALF]) && ref_fall));

    // ==========================================================
    // Recentre sequence
    tpa_rc_state_t rc_ff;
    logic          rc_pulse;

    // Wait for the first capture or character edge, whichever comes first, then pulse the clear for one cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rc_ff <= TPA_RC_IDLE;
        else
        begin
            case (rc_ff)
                TPA_RC_IDLE:  if (rc_write) rc_ff <= TPA_RC_ARM;
                TPA_RC_ARM:   if (cap_stb || chr_stb) rc_ff <= TPA_RC_CLEAR; // RULE15
                TPA_RC_CLEAR: rc_ff <= TPA_RC_IDLE;
                default:      rc_ff <= TPA_RC_IDLE;
            endcase
        end
    end

    assign rc_pulse = (rc_ff == TPA_RC_CLEAR);

    // ==========================================================
    // Phase-align buffer
    tpa_fifo_if #(.W(W), .LW(LW)) fif ();

    assign fif.wr_valid = cap_stb && (rc_ff == TPA_RC_IDLE);
    assign fif.wr_data  = chr_s2_ff;
    assign fif.rd_ready = chr_stb && (rc_ff == TPA_RC_IDLE);
    assign fif.recenter = rc_pulse;

    tpa_fifo #(.W(W), .DEPTH(DEPTH), .LW(LW)) u_fifo
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .f       (fif)
    );

    // Character out to the serializer on each character clock
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_char_out   <= '0;
            tx_char_valid <= 1'b0;
        end
        else
        begin
            tx_char_valid <= fif.rd_ready && fif.rd_valid;
            if (fif.rd_ready && fif.rd_valid)
                tx_char_out <= fif.rd_data;
        end
    end

    // ==========================================================
    // Error sources
    logic       buf_err_ff;
    logic [7:0] loss_cnt_ff;
    logic       ref_lost_ff;
    logic [8:0] bist_cnt_ff;
    logic       bist_pulse_ff;

    // Sticky buffer fault; a new fault in the clearing cycle wins
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            buf_err_ff <= 1'b0;
        else if (fif.overflow || fif.underflow)
            buf_err_ff <= 1'b1; // RULE3 RULE10
        else if (rc_pulse)
            buf_err_ff <= 1'b0; // RULE3
    end

    // Reference watchdog: no edge for too long means the clock is gone
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            loss_cnt_ff <= 8'h00;
            ref_lost_ff <= 1'b1;
        end
        else if (ref_rise || ref_fall)
        begin
            loss_cnt_ff <= 8'h00;
            ref_lost_ff <= 1'b0;
        end
        else if (loss_cnt_ff == 8'(`TPA_REF_LOSS_CYC))
            ref_lost_ff <= 1'b1; // RULE7
        else
            loss_cnt_ff <= 8'(loss_cnt_ff + 1'b1);
    end

    // Self-test sequence counter; pulse lasts one character period
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bist_cnt_ff   <= 9'h000;
            bist_pulse_ff <= 1'b0;
        end
        else if (ctrl_ff[`TPA_CTRL_BIST_N])
        begin
            bist_cnt_ff   <= 9'h000;
            bist_pulse_ff <= 1'b0;
        end
        else if (chr_stb)
        begin
            bist_pulse_ff <= (bist_cnt_ff == 9'(`TPA_BIST_LEN - 1)); // RULE5
            bist_cnt_ff   <= (bist_cnt_ff == 9'(`TPA_BIST_LEN - 1)) ? 9'h000 : 9'(bist_cnt_ff + 1'b1);
        end
    end

    // Combined error; level sources act at once, not on a character edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            tx_path_error <= 1'b1;
        else
            tx_path_error <= buf_err_ff || bist_pulse_ff || pll_down || ref_lost_ff; // RULE6 RULE8 RULE11
    end

    assign stat_word = {20'h0, 4'(fif.level), 3'h0, (rc_ff != TPA_RC_IDLE),
                        pll_down, ref_lost_ff, buf_err_ff, tx_path_error};

    // ==========================================================
    // Transmit clock output and PLL power
    logic [3:0] qtr_cnt_ff;

    // Rate 1 adds a toggle a quarter period after each reference edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            qtr_cnt_ff             <= 4'h0;
            tx_clock_out           <= 1'b0;
            tx_synth_pll_powerdown <= 1'b1;
        end
        else
        begin
            tx_synth_pll_powerdown <= pll_down; // RULE6
            if (ref_rise || ref_fall)
                qtr_cnt_ff <= 4'h0;
            else if (qtr_cnt_ff != 4'hf)
                qtr_cnt_ff <= 4'(qtr_cnt_ff + 1'b1);
            if (pll_down || ref_lost_ff)
                tx_clock_out <= 1'b0;
            else if (!ctrl_ff[`TPA_CTRL_RATE])
                tx_clock_out <= ref_s2_ff; // RULE12
            else if ((ref_rise || ref_fall) || qtr_cnt_ff == 4'(`TPA_REF_QTR_CYC))
                tx_clock_out <= !tx_clock_out; // RULE12
        end
    end
endmodule

// *** tb/tpa_host_model.sv ***
// Host side model: character source, host capture clock and reference clock
`timescale 1ns/1ps
module tpa_host_model
(
    input  wire logic  ref_run,
    input  wire logic  host_run,
    output logic       ref_clk,
    output logic       host_clk,
    output logic [9:0] chr
);
    logic phase;
    // One timebase for both clocks keeps them frequency-coherent, no drift
    initial
    begin
        phase = 1'b0;
        chr   = 10'h0;
        // Offset keeps pin edges off the sampling clock's edges
        #1;
        forever
        begin
            #62.5 phase = ~phase;
            // New character at the falling edge, centred on the capture edges
            if (!phase)
                chr = chr + 10'h1;
        end
    end
    // A stopped clock rests low, as the pin is pulled down
    assign ref_clk  = ref_run & phase;
    assign host_clk = host_run & phase;
endmodule

// *** tb/tpa_top_monitor.sv ***
// Checker on the ports of the transmit phase-align stage
`timescale 1ns/1ps
module tpa_top_monitor #(parameter int W = 10)
(
    input wire logic         hclk,
    input wire logic         hresetn,
    input wire logic         hsel,
    input wire logic [1:0]   htrans,
    input wire logic         hwrite,
    input wire logic         hready,
    input wire logic         hreadyout,
    input wire logic [31:0]  hrdata,
    input wire logic         hresp,
    input wire logic         tx_reference_clock,
    input wire logic [W-1:0] tx_char_out,
    input wire logic         tx_char_valid,
    input wire logic         tx_clock_out,
    input wire logic         tx_path_error,
    input wire logic         tx_synth_pll_powerdown
);
    // ==========================================================
    // Helpers
    logic       rd_ph_ff;
    logic [5:0] ref_age_ff;
    // A read data phase follows each taken read address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rd_ph_ff <= 1'b0;
        else
            rd_ph_ff <= hsel & hready & htrans[1] & !hwrite;
    end
    // Age of the last reference pin movement, saturating so it never wraps
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ref_age_ff <= 6'h0;
        else if ($changed(tx_reference_clock))
            ref_age_ff <= 6'h0;
        else if (ref_age_ff != 6'h3f)
            ref_age_ff <= ref_age_ff + 6'h1;
    end
    // ==========================================================
    // Properties
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Margin of four cycles covers the registered enable decode
    sequence s_down;
        tx_synth_pll_powerdown [*4];
    endsequence
    a_resp_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
        else $error("bus answer not OKAY without wait");
    a_rdata_idle: assert property (!rd_ph_ff |-> hrdata == 32'h0)
        else $error("read data outside a read data phase");
    a_down_error: assert property (s_down |-> tx_path_error)
        else $error("error low while the PLL is down");
    a_down_quiet: assert property (s_down |-> !tx_clock_out && !tx_char_valid)
        else $error("clock or characters while the PLL is down");
    a_ref_loss: assert property (ref_age_ff >= 6'h1e |-> tx_path_error)
        else $error("error low with the reference stopped");
    a_err_clear: assert property ($fell(tx_path_error) |-> ref_age_ff < 6'h1e && !tx_synth_pll_powerdown)
        else $error("error fell while a cause remains");
    a_valid_pulse: assert property (tx_char_valid |=> !tx_char_valid)
        else $error("character strobe longer than a cycle");
    a_out_hold: assert property ($changed(tx_char_out) |-> tx_char_valid)
        else $error("character output changed without a strobe");
endmodule

bind tpa_top tpa_top_monitor #(.W(W)) tpa_top_monitor_inst
(
    .hclk                   (hclk),
    .hresetn                (hresetn),
    .hsel                   (hsel),
    .htrans                 (htrans),
    .hwrite                 (hwrite),
    .hready                 (hready),
    .hreadyout              (hreadyout),
    .hrdata                 (hrdata),
    .hresp                  (hresp),
    .tx_reference_clock     (tx_reference_clock),
    .tx_char_out            (tx_char_out),
    .tx_char_valid          (tx_char_valid),
    .tx_clock_out           (tx_clock_out),
    .tx_path_error          (tx_path_error),
    .tx_synth_pll_powerdown (tx_synth_pll_powerdown)
);

// *** tb/tpa_top_tb.sv ***
// Testbench of the transmit phase-align stage
`timescale 1ns/1ps
`include "tpa_regs.svh"
module tpa_top_tb;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic        ref_run, host_run, ref_clk, host_clk, tx_char_valid, tx_clock_out, tx_path_error, pll_dn;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [9:0]  chr, tx_char_out;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          n_fail, checks_done, cyc, k, w, p;
    localparam logic [7:0]  CT  = `TPA_CTRL_OFS;
    localparam logic [7:0]  ST  = `TPA_STAT_OFS;
    localparam logic [31:0] OE  = (32'h1 << `TPA_CTRL_OE1) | (32'h1 << `TPA_CTRL_OE2);
    localparam logic [31:0] BN  = 32'h1 << `TPA_CTRL_BIST_N;
    localparam logic [31:0] RF  = 32'h1 << `TPA_CTRL_CKSEL;
    // ==========================================================
    // Design and host model
    tpa_top #(.W(10), .DEPTH(8)) tpa_top_inst
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .tx_char_in(chr), .tx_host_input_clock(host_clk), .tx_reference_clock(ref_clk),
        .tx_char_out(tx_char_out), .tx_char_valid(tx_char_valid), .tx_clock_out(tx_clock_out),
        .tx_path_error(tx_path_error), .tx_synth_pll_powerdown(pll_dn)
    );
    tpa_host_model tpa_host_model_inst
    (
        .ref_run(ref_run), .host_run(host_run), .ref_clk(ref_clk), .host_clk(host_clk), .chr(chr)
    );
    // ==========================================================
    // Clock and hang guard; the self-test needs about 13000 cycles
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            n_fail++;
            end_of_test();
        end
    end
    // ==========================================================
    // Tasks
    task end_of_test;
        $display("checks_done %0d n_fail %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One single transfer; the bus waits on hready, never on a fixed count
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task rdchk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, exp, rd & m);
    endtask
    task wait_err(input logic v, input int n);
        repeat (n) if (tx_path_error !== v) @(negedge hclk);
        chk("tx_path_error", {31'h0, v}, {31'h0, tx_path_error});
    endtask
    // Each character follows its predecessor, as the host counts them
    task check_seq(input int n);
        logic [9:0] prev;
        for (int i = 0; i < n; i++)
        begin
            do @(negedge hclk); while (tx_char_valid !== 1'b1);
            if (i > 0)
                chk("tx_char_out", {22'h0, prev + 10'h1}, {22'h0, tx_char_out});
            prev = tx_char_out;
        end
    endtask
    task count_rises(input int n);
        logic q;
        k = 0;
        q = tx_clock_out;
        repeat (n)
        begin
            @(negedge hclk);
            if (tx_clock_out === 1'b1 && q === 1'b0)
                k++;
            q = tx_clock_out;
        end
    endtask
    // ==========================================================
    // Main sequence; every control write with the recentre bit at 0 recentres
    initial
    begin
        {hsel, hwrite, htrans, haddr, hwdata, n_fail, checks_done, cyc, hresetn} = '0;
        hsize    = 3'b010;
        ref_run  = 1'b1;
        host_run = 1'b1;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk("ctrl", CT, 32'hffffffff, {25'h0, `TPA_CTRL_RST});
        bus(1'b1, 8'h10, 32'hffffffff);
        rdchk("unmapped", 8'h10, 32'hffffffff, 32'h0);
        bus(1'b1, CT, OE | BN);
        // Recentre must finish and stale entries drain before data are judged
        repeat (100) @(negedge hclk);
        wait_err(1'b0, 300);
        rdchk("status", ST, 32'h1f, 32'h0);
        $display("test registers done");
        check_seq(6);
        host_run <= 1'b0;
        wait_err(1'b1, 200);
        host_run <= 1'b1;
        repeat (100) @(negedge hclk);
        wait_err(1'b1, 1);
        rdchk("buf_err", ST, 32'h2, 32'h2);
        bus(1'b1, CT, OE | BN | (32'h1 << `TPA_CTRL_RECENTER));
        repeat (50) @(negedge hclk);
        wait_err(1'b1, 1);
        bus(1'b1, CT, OE | BN);
        wait_err(1'b0, 300);
        rdchk("buf_err", ST, 32'h2, 32'h0);
        repeat (100) @(negedge hclk);
        check_seq(4);
        $display("test host capture done");
        host_run <= 1'b0;
        bus(1'b1, CT, OE | BN | RF);
        repeat (300) @(negedge hclk);
        wait_err(1'b0, 1);
        check_seq(4);
        host_run <= 1'b1;
        bus(1'b1, CT, OE | BN | RF | (32'h1 << `TPA_CTRL_HALF));
        repeat (300) @(negedge hclk);
        wait_err(1'b0, 1);
        $display("test reference capture done");
        bus(1'b1, CT, OE | BN | RF);
        count_rises(250);
        chk("rises_rate0", 32'h1, {31'h0, k >= 19 && k <= 21});
        bus(1'b1, CT, OE | BN | RF | (32'h1 << `TPA_CTRL_RATE));
        count_rises(250);
        chk("rises_rate1", 32'h1, {31'h0, k >= 39 && k <= 41});
        bus(1'b1, CT, BN | RF);
        wait_err(1'b1, 20);
        repeat (50) @(negedge hclk);
        chk("pll_down", 32'h1, {31'h0, pll_dn});
        rdchk("pll_stat", ST, 32'h8, 32'h8);
        bus(1'b1, CT, OE | BN | RF);
        wait_err(1'b0, 300);
        ref_run <= 1'b0;
        wait_err(1'b1, 60);
        rdchk("ref_lost", ST, 32'h4, 32'h4);
        ref_run <= 1'b1;
        bus(1'b1, CT, OE | BN | RF);
        wait_err(1'b0, 300);
        $display("test rate power and reference done");
        bus(1'b1, CT, OE | RF);
        wait_err(1'b0, 300);
        do @(negedge hclk); while (tx_path_error !== 1'b1);
        w = 0;
        do
        begin
            @(negedge hclk);
            w++;
        end
        while (tx_path_error === 1'b1);
        p = w;
        do
        begin
            @(negedge hclk);
            p++;
        end
        while (tx_path_error !== 1'b1);
        chk("bist_width", 32'h1, {31'h0, w >= 12 && w <= 13});
        chk("bist_period", 32'h1, {31'h0, p >= 6386 && p <= 6389});
        $display("test self-test done");
        end_of_test();
    end
endmodule
